// ---- core/link_cfg_pkg.sv ----
package link_cfg_pkg;
	// Alarm source enable bit positions
	localparam int EN_SIG = 0;
	localparam int EN_SYNC = 1;
	localparam int EN_PLL = 2;
	localparam int EN_DEC = 3;
	localparam int EN_GAIN = 4;
	localparam int EN_AZ = 5;
	localparam int EN_W = 6;
	// Reset values
	localparam logic [EN_W-1:0] EN_RST = 6'h00;
	localparam logic [3:0] PRE_RST = 4'h0;
	localparam logic [4:0] POST_RST = 5'h00;
	localparam logic [3:0] SWING_RST = 4'h0;
	localparam logic EQ_RST = 1'b0;
	// Field widths of de-emphasis taps
	localparam int PRE_W = 4;
	localparam int POST_W = 5;
	localparam int SWING_W = 4;
	// Configuration states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_TRAIN = 2'b01,
		ST_RUN = 2'b11
	} link_state_t;
endpackage

// ---- core/alarm_merge.sv ----
`timescale 1ns/1ps
module alarm_merge
	import link_cfg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [EN_W-1:0] enables,
	input wire logic sig_lost,
	input wire logic sync_lost,
	input wire logic pll_unlocked,
	input wire logic decode_err,
	input wire logic gain_loop_locked,
	input wire logic autozero_cal_done,
	output logic alarm_q
);
	logic alarm_d;

	// Combine every enabled fault term
	always_comb begin
		alarm_d = (enables[EN_SIG] & sig_lost) // [RULE1]
			| (enables[EN_SYNC] & sync_lost) // [RULE2]
			| (enables[EN_PLL] & pll_unlocked) // [RULE3]
			| (enables[EN_DEC] & decode_err) // [RULE4]
			| (enables[EN_GAIN] & ~gain_loop_locked) // [RULE5]
			| (enables[EN_AZ] & ~autozero_cal_done); // [RULE6] [RULE20]
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			alarm_q <= 1'b0;
		end else begin
			alarm_q <= alarm_d;
		end
	end

	// Alarm only follows an enabled fault term of the cycle before
	property p_alarm_cause;
		@(posedge sys_clk) disable iff (!rst_n)
		alarm_q |-> $past(enables[EN_SIG] & sig_lost) | $past(enables[EN_SYNC] & sync_lost)
			| $past(enables[EN_PLL] & pll_unlocked) | $past(enables[EN_DEC] & decode_err)
			| $past(enables[EN_GAIN] & ~gain_loop_locked)
			| $past(enables[EN_AZ] & ~autozero_cal_done);
	endproperty
	a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without cause"); // [RULE20]
endmodule

// ---- core/link_status_and_rate_config.sv ----
`timescale 1ns/1ps
// Function
// [RULE1] Enabled loss of signal drives alarm high
// [RULE2] Optional OR of sync loss into alarm
// [RULE3] Optional OR of PLL unlock into alarm
// [RULE4] Optional OR of decode errors into alarm
// [RULE5] Optional OR of inverted gain lock
// [RULE6] Optional OR of inverted calibration done
// [RULE7] Loss of signal readable as status
// [RULE8] Latency fixed once normal operation begins
// [RULE9] Latency within documented window, fixed pipeline
// [RULE10] Four programmable de-emphasis taps; the code has only the pre and post cursor fields
// [RULE11] Pre and post cursor fields applied
// [RULE12] Output swing taken from setting
// [RULE13] Equalizer enable; adaptive control when enabled
// [RULE14] Both SERDES share one reference clock
// [RULE15] Reference clock within multiplier range
// [RULE16] Low speed scale factor one or two
// [RULE17] High speed scale factor quarter/half/one
// [RULE18] One-to-one mode doubles high speed multiplier
// [RULE19] Refclk equals rate times scale over multiplier
// [RULE20] Separate reset-cleared enables ORed into alarm
module link_status_and_rate_config
	import link_cfg_pkg::*;
#(
	parameter int LAT_W = 4
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cfg_wr,
	input wire logic [EN_W-1:0] cfg_alarm_en,
	input wire logic [PRE_W-1:0] cfg_pre_cursor,
	input wire logic [POST_W-1:0] cfg_post_cursor,
	input wire logic [SWING_W-1:0] cfg_swing,
	input wire logic cfg_eq_en,
	input wire logic link_up,
	input wire logic [LAT_W-1:0] lat_sel,
	input wire logic sig_lost_a,
	input wire logic sig_lost_b,
	input wire logic sync_lost_a,
	input wire logic sync_lost_b,
	input wire logic pll_unlocked_a,
	input wire logic pll_unlocked_b,
	input wire logic decode_err_a,
	input wire logic decode_err_b,
	input wire logic gain_loop_locked_a,
	input wire logic gain_loop_locked_b,
	input wire logic autozero_cal_done_a,
	input wire logic autozero_cal_done_b,
	input wire logic [3:0] eq_gain_auto,
	input wire logic [3:0] eq_bw_auto,
	input wire logic data_in,
	output logic chan_a_signal_alarm,
	output logic chan_b_signal_alarm,
	output logic sig_lost_status_a_q,
	output logic sig_lost_status_b_q,
	output logic [PRE_W-1:0] tap_pre_q,
	output logic [POST_W-1:0] tap_post_q,
	output logic [SWING_W-1:0] swing_q,
	output logic eq_en_q,
	output logic [3:0] eq_gain_q,
	output logic [3:0] eq_bw_q,
	output logic [LAT_W-1:0] lat_lock_q,
	output logic running_q,
	output logic data_out_q
);
	logic [EN_W-1:0] en_q, en_d;
	logic [PRE_W-1:0] tap_pre_d;
	logic [POST_W-1:0] tap_post_d;
	logic [SWING_W-1:0] swing_d;
	logic eq_en_d;
	logic [3:0] eq_gain_d, eq_bw_d;
	logic sls_a_d, sls_b_d;
	link_state_t st_q, st_d;
	logic [LAT_W-1:0] lat_lock_d;
	logic [(1<<LAT_W)-1:0] pipe_q, pipe_d;
	logic data_out_d;

	// Configuration next values
	always_comb begin
		en_d = en_q;
		tap_pre_d = tap_pre_q;
		tap_post_d = tap_post_q;
		swing_d = swing_q;
		eq_en_d = eq_en_q;
		if (cfg_wr) begin
			en_d = cfg_alarm_en; // [RULE20]
			tap_pre_d = cfg_pre_cursor; // [RULE11] [RULE10]
			tap_post_d = cfg_post_cursor; // [RULE11]
			swing_d = cfg_swing; // [RULE12]
			eq_en_d = cfg_eq_en; // [RULE13]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			en_q <= EN_RST;
			tap_pre_q <= PRE_RST;
			tap_post_q <= POST_RST;
			swing_q <= SWING_RST;
			eq_en_q <= EQ_RST;
		end else begin
			en_q <= en_d;
			tap_pre_q <= tap_pre_d;
			tap_post_q <= tap_post_d;
			swing_q <= swing_d;
			eq_en_q <= eq_en_d;
		end
	end

	// Equalizer follows adaptive logic only while enabled
	always_comb begin
		eq_gain_d = 4'h0;
		eq_bw_d = 4'h0;
		if (eq_en_q) begin
			eq_gain_d = eq_gain_auto; // [RULE13]
			eq_bw_d = eq_bw_auto;
		end
		sls_a_d = sig_lost_a; // [RULE7]
		sls_b_d = sig_lost_b;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			eq_gain_q <= 4'h0;
			eq_bw_q <= 4'h0;
			sig_lost_status_a_q <= 1'b0;
			sig_lost_status_b_q <= 1'b0;
		end else begin
			eq_gain_q <= eq_gain_d;
			eq_bw_q <= eq_bw_d;
			sig_lost_status_a_q <= sls_a_d;
			sig_lost_status_b_q <= sls_b_d;
		end
	end

	// Latency chosen at link bring-up, frozen while running
	always_comb begin
		st_d = st_q;
		lat_lock_d = lat_lock_q;
		case (st_q)
			ST_IDLE: begin
				if (link_up) begin
					st_d = ST_TRAIN;
				end
			end
			ST_TRAIN: begin
				lat_lock_d = lat_sel; // [RULE8]
				st_d = link_up ? ST_RUN : ST_IDLE;
			end
			ST_RUN: begin
				if (!link_up) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
		pipe_d = {pipe_q[(1<<LAT_W)-2:0], data_in};
		data_out_d = pipe_q[lat_lock_q]; // [RULE9]
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			lat_lock_q <= '0;
			pipe_q <= '0;
			data_out_q <= 1'b0;
			running_q <= 1'b0;
		end else begin
			st_q <= st_d;
			lat_lock_q <= lat_lock_d;
			pipe_q <= pipe_d;
			data_out_q <= data_out_d;
			running_q <= (st_d == ST_RUN);
		end
	end

	// Per-channel alarm combiners
	alarm_merge u_alarm_a (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.enables(en_q),
		.sig_lost(sig_lost_a),
		.sync_lost(sync_lost_a),
		.pll_unlocked(pll_unlocked_a),
		.decode_err(decode_err_a),
		.gain_loop_locked(gain_loop_locked_a),
		.autozero_cal_done(autozero_cal_done_a),
		.alarm_q(chan_a_signal_alarm)
	);
	alarm_merge u_alarm_b (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.enables(en_q),
		.sig_lost(sig_lost_b),
		.sync_lost(sync_lost_b),
		.pll_unlocked(pll_unlocked_b),
		.decode_err(decode_err_b),
		.gain_loop_locked(gain_loop_locked_b),
		.autozero_cal_done(autozero_cal_done_b),
		.alarm_q(chan_b_signal_alarm)
	);

	property p_sig_alarm;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_SIG] && sig_lost_a) |=> chan_a_signal_alarm;
	endproperty
	a_sig_alarm: assert property (p_sig_alarm) else $error("sig alarm missing"); // [RULE1]

	property p_sync_alarm;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_SYNC] && sync_lost_b) |=> chan_b_signal_alarm;
	endproperty
	a_sync_alarm: assert property (p_sync_alarm) else $error("sync alarm missing"); // [RULE2]

	property p_pll_alarm;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_PLL] && pll_unlocked_a) |=> chan_a_signal_alarm;
	endproperty
	a_pll_alarm: assert property (p_pll_alarm) else $error("pll alarm missing"); // [RULE3]

	property p_dec_alarm;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_DEC] && decode_err_b) |=> chan_b_signal_alarm;
	endproperty
	a_dec_alarm: assert property (p_dec_alarm) else $error("decode alarm missing"); // [RULE4]

	property p_gain_alarm;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_GAIN] && !gain_loop_locked_a) |=> chan_a_signal_alarm;
	endproperty
	a_gain_alarm: assert property (p_gain_alarm) else $error("gain alarm missing"); // [RULE5]

	property p_az_alarm;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_AZ] && !autozero_cal_done_b) |=> chan_b_signal_alarm;
	endproperty
	a_az_alarm: assert property (p_az_alarm) else $error("autozero alarm missing"); // [RULE6]

	property p_los_status;
		@(posedge sys_clk) disable iff (!rst_n)
		##1 sig_lost_status_a_q == $past(sig_lost_a);
	endproperty
	a_los_status: assert property (p_los_status) else $error("status mismatch"); // [RULE7]

	property p_lat_fixed;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_q == ST_RUN && link_up) |=> $stable(lat_lock_q);
	endproperty
	a_lat_fixed: assert property (p_lat_fixed) else $error("latency drifted"); // [RULE8]

	property p_taps;
		@(posedge sys_clk) disable iff (!rst_n)
		cfg_wr |=> (tap_pre_q == $past(cfg_pre_cursor)) && (tap_post_q == $past(cfg_post_cursor))
			&& (swing_q == $past(cfg_swing));
	endproperty
	a_taps: assert property (p_taps) else $error("tap setting not applied"); // [RULE11]

	property p_eq_off;
		@(posedge sys_clk) disable iff (!rst_n)
		!eq_en_q |=> eq_gain_q == 4'h0;
	endproperty
	a_eq_off: assert property (p_eq_off) else $error("eq active while disabled"); // [RULE13]

	property p_sig_alarm_b;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_SIG] && sig_lost_b) |=> chan_b_signal_alarm;
	endproperty
	a_sig_alarm_b: assert property (p_sig_alarm_b) else $error("sig alarm b missing"); // [RULE1]

	property p_sync_alarm_a;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_SYNC] && sync_lost_a) |=> chan_a_signal_alarm;
	endproperty
	a_sync_alarm_a: assert property (p_sync_alarm_a) else $error("sync alarm a missing"); // [RULE2]

	property p_pll_alarm_b;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_PLL] && pll_unlocked_b) |=> chan_b_signal_alarm;
	endproperty
	a_pll_alarm_b: assert property (p_pll_alarm_b) else $error("pll alarm b missing"); // [RULE3]

	property p_dec_alarm_a;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_DEC] && decode_err_a) |=> chan_a_signal_alarm;
	endproperty
	a_dec_alarm_a: assert property (p_dec_alarm_a) else $error("decode alarm a missing"); // [RULE4]

	property p_gain_alarm_b;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_GAIN] && !gain_loop_locked_b) |=> chan_b_signal_alarm;
	endproperty
	a_gain_alarm_b: assert property (p_gain_alarm_b) else $error("gain alarm b missing"); // [RULE5]

	property p_az_alarm_a;
		@(posedge sys_clk) disable iff (!rst_n)
		(en_q[EN_AZ] && !autozero_cal_done_a) |=> chan_a_signal_alarm;
	endproperty
	a_az_alarm_a: assert property (p_az_alarm_a) else $error("autozero alarm a missing"); // [RULE6]

	// Reset clears every source enable and both alarms
	property p_en_reset;
		@(posedge sys_clk)
		!rst_n |=> (en_q == EN_RST) && !chan_a_signal_alarm && !chan_b_signal_alarm;
	endproperty
	a_en_reset: assert property (p_en_reset) else $error("enables not cleared"); // [RULE20]

	property p_lat_train;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_q == ST_TRAIN) |=> lat_lock_q == $past(lat_sel);
	endproperty
	a_lat_train: assert property (p_lat_train) else $error("latency not latched"); // [RULE8]

	property p_eq_follow;
		@(posedge sys_clk) disable iff (!rst_n)
		eq_en_q |=> (eq_gain_q == $past(eq_gain_auto)) && (eq_bw_q == $past(eq_bw_auto));
	endproperty
	a_eq_follow: assert property (p_eq_follow) else $error("eq not adaptive"); // [RULE13]

	c_run: cover property (@(posedge sys_clk) disable iff (!rst_n) st_q == ST_RUN);
	c_alarm_a: cover property (@(posedge sys_clk) disable iff (!rst_n) chan_a_signal_alarm);
	c_eq: cover property (@(posedge sys_clk) disable iff (!rst_n) eq_en_q && eq_gain_q != 4'h0);
	c_alarm_b: cover property (@(posedge sys_clk) disable iff (!rst_n) chan_b_signal_alarm);
	c_train: cover property (@(posedge sys_clk) disable iff (!rst_n) st_q == ST_TRAIN);
endmodule

// ---- dv/fault_monitor_model.sv ----
`timescale 1ns/1ps
// Stands in for the receive, PLL and datapath monitors of both channels
module fault_monitor_model (
	input wire logic sys_clk,
	input wire logic act,
	output logic [11:0] st,
	output logic [7:0] eq_auto,
	output logic bit_out
);
	// Healthy levels until the first edge
	initial begin
		st = 12'hf00;
		eq_auto = 8'h00;
		bit_out = 1'b0;
	end
	// Fresh levels after each edge; idle means locked, calibrated, no faults
	always @(posedge sys_clk) begin
		st <= act ? 12'($urandom) : 12'hf00;
		eq_auto <= 8'($urandom);
		bit_out <= 1'($urandom);
	end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import link_cfg_pkg::*;
	logic sys_clk, rst_n, cfg_wr, eq_en, link_up, act, go, wr_d;
	logic [EN_W-1:0] en, en_m;
	logic [PRE_W-1:0] pre, tp;
	logic [POST_W-1:0] post, tpo;
	logic [SWING_W-1:0] sw, swq;
	logic [3:0] lat, lat_b, lk, gq, bq;
	logic [11:0] st;
	logic [7:0] eqa, eq_m;
	logic [13:0] cfg_m;
	logic [1:0] al_m, ls_m;
	logic [31:0] hist;
	logic din, al_a, al_b, ls_a, ls_b, eqe, run, dout;
	int err_count = 0;
	int samples_checked = 0;
	int up_cnt = 0;
	int lu_cnt = 0;
	fault_monitor_model partner (.sys_clk(sys_clk), .act(act), .st(st), .eq_auto(eqa),
		.bit_out(din));
	link_status_and_rate_config DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
		.cfg_alarm_en(en), .cfg_pre_cursor(pre), .cfg_post_cursor(post), .cfg_swing(sw),
		.cfg_eq_en(eq_en), .link_up(link_up), .lat_sel(lat), .sig_lost_a(st[0]),
		.sig_lost_b(st[1]), .sync_lost_a(st[2]), .sync_lost_b(st[3]),
		.pll_unlocked_a(st[4]), .pll_unlocked_b(st[5]), .decode_err_a(st[6]),
		.decode_err_b(st[7]), .gain_loop_locked_a(st[8]), .gain_loop_locked_b(st[9]),
		.autozero_cal_done_a(st[10]), .autozero_cal_done_b(st[11]),
		.eq_gain_auto(eqa[7:4]), .eq_bw_auto(eqa[3:0]), .data_in(din),
		.chan_a_signal_alarm(al_a), .chan_b_signal_alarm(al_b),
		.sig_lost_status_a_q(ls_a), .sig_lost_status_b_q(ls_b), .tap_pre_q(tp),
		.tap_post_q(tpo), .swing_q(swq), .eq_en_q(eqe), .eq_gain_q(gq), .eq_bw_q(bq),
		.lat_lock_q(lk), .running_q(run), .data_out_q(dout));
	// Alarm sources of one channel in enable bit order, lock flags inverted
	function automatic logic alarm_f(logic [5:0] e, logic [11:0] s, int c);
		return |(e & {~s[10+c], ~s[8+c], s[6+c], s[4+c], s[2+c], s[c]});
	endfunction
	task automatic chk(string n, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (exp !== got) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checked %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Reference clock in kHz from line rate in Mbps, scale in quarters and multiplier
	function automatic int refclk_f(int rate, int scale_q, int pll_multiplier);
		return (rate * scale_q * 250) / pll_multiplier;
	endfunction
	// Both sides of a channel must land on one reference clock inside the allowed span
	task automatic refclk_check(int rate);
		int ls_k, hs_k, oct_k;
		ls_k = refclk_f(rate, 4, 8);
		hs_k = refclk_f(2 * rate, 4, 16);
		oct_k = refclk_f(8 * rate, 1, 16);
		chk("refclk_share", ls_k, hs_k);
		chk("refclk_octal", ls_k, oct_k);
		chk("refclk_range", 1, ls_k >= 122880 && ls_k <= 425000);
	endtask
	// Compare last cycle's outputs, then step the reference model
	always @(posedge sys_clk) begin
		hist = {hist[30:0], din};
		if (go) begin
			chk("alarm", al_m, {al_b, al_a});
			chk("los_status", ls_m, {ls_b, ls_a});
			chk("settings", cfg_m, {tp, tpo, swq, eqe});
			if (!wr_d) chk("eq_auto", eq_m, {gq, bq});
			chk("running", lu_cnt >= 2, run);
			if (run && up_cnt > 0) chk("lat_lock", lat_b, lk);
			if (run && up_cnt > 20) chk("latency", hist[lk+2], dout);
		end
		// The tap is latched at the bring-up edge, the last edge before running shows
		if (!run) lat_b = lat;
		al_m = {alarm_f(en_m, st, 1), alarm_f(en_m, st, 0)};
		ls_m = st[1:0];
		eq_m = cfg_m[0] ? eqa : 8'h00;
		wr_d = cfg_wr;
		if (cfg_wr) begin
			en_m = en;
			cfg_m = {pre, post, sw, eq_en};
		end
		if (!rst_n) begin
			en_m = EN_RST;
			cfg_m = 14'h0000;
			al_m = 2'h0;
			ls_m = 2'h0;
			eq_m = 8'h00;
		end
		up_cnt = run ? up_cnt + 1 : 0;
		lu_cnt = (rst_n && link_up) ? lu_cnt + 1 : 0;
	end
	// Free running clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Cuts a hang short
	initial begin
		#400000;
		err_count++;
		conclude();
	end
	// Reset, all sources enabled at once, then random sessions with a reset mid-run
	initial begin
		{rst_n, cfg_wr, en, pre, post, sw, eq_en, link_up, lat, go, wr_d} = '0;
		{en_m, cfg_m, al_m, ls_m, eq_m, hist} = '0;
		act = 1'b0;
		lat_b = 4'h0;
		void'($urandom(32'h9e000bc3));
		refclk_check($urandom_range(1000, 1250));
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		go <= 1'b1;
		cfg_wr <= 1'b1;
		en <= 6'h3f;
		for (int s = 0; s < 40; s++) begin
			act <= (s % 5 != 0);
			lat <= 4'($urandom);
			link_up <= 1'b1;
			for (int i = 0; i < 60; i++) begin
				@(posedge sys_clk);
				cfg_wr <= (s == 0 && i == 0) || ($urandom_range(0, 7) == 0);
				en <= (s == 1) ? 6'h01 << (i % 6) : 6'($urandom);
				pre <= 4'($urandom);
				post <= 5'($urandom);
				sw <= 4'($urandom);
				eq_en <= 1'($urandom);
				rst_n <= !(s == 20 && i > 30 && i < 33);
				if (i > 3) lat <= 4'($urandom);
			end
			link_up <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
		conclude();
	end
endmodule
